// file: uadc_host_model.sv
// Behavioural host port that watches D+ through its pull-down
`timescale 1ns/10ps
module uadc_host_model
(
  input wire logic dplus_i,
  input wire logic dplus_oe_i,
  input wire logic pullup_i,
  input wire logic ext_oe_i,
  input wire logic ext_i,
  output logic line_o
);
  // Undriven D+ falls to the host pull-down unless a pull-up acts
  assign line_o = dplus_oe_i ? dplus_i :
    (pullup_i | (ext_oe_i & ext_i));
endmodule

// file: uadc_pkg.sv
// Package with register map, field positions and constants for attach control
package uadc_pkg;
  localparam logic [11:0] UADC_CTRL_OFF = 12'h000;
  localparam logic [11:0] UADC_PIN_OFF = 12'h004;
  localparam logic [11:0] UADC_STAT_OFF = 12'h008;
  localparam logic [11:0] UADC_IRQ_OFF = 12'h00c;
  localparam logic [11:0] UADC_MASK_OFF = 12'h010;
  localparam logic [11:0] UADC_POWER_OFF = 12'h014;
  localparam int UADC_NPIO = 16;
  localparam int UADC_PSEL_W = 4;
  // Control register fields
  localparam int CTRL_READY_BIT = 0;
  localparam int CTRL_EXTPU_BIT = 1;
  localparam int CTRL_SELFPWR_BIT = 2;
  localparam int CTRL_WAKE_BIT = 3;
  localparam int CTRL_SUSPEND_BIT = 4;
  localparam int CTRL_LEDOFF_BIT = 5;
  localparam logic [5:0] CTRL_RESET = 6'h00;
  // Pin select register fields
  localparam int PIN_VBUS_LSB = 0;
  localparam int PIN_DET_LSB = 4;
  localparam int PIN_WAKE_LSB = 8;
  localparam int PIN_PULL_LSB = 12;
  localparam logic [15:0] PIN_RESET = 16'h3210;
  // Status and interrupt fields
  localparam int EV_DETACH_BIT = 0;
  localparam int EV_ATTACH_BIT = 1;
  localparam int EV_VBUS_ON_BIT = 2;
  localparam int EV_VBUS_OFF_BIT = 3;
  localparam int UADC_NEV = 4;
  localparam logic [3:0] IRQ_RESET = 4'h0;
  localparam logic [3:0] MASK_RESET = 4'h0;
  localparam logic [7:0] POWER_RESET = 8'h32;
  localparam int UADC_LINE_RATE_MBPS = 12;
  typedef enum logic [2:0] {
    UADC_OFF = 3'b001,
    UADC_ATTACHED = 3'b010,
    UADC_DETACHED = 3'b100
  } uadc_state_type;
endpackage

// file: uadc_sync.sv
// Two-flop synchroniser for the general I/O input pins
`timescale 1ns/10ps
module uadc_sync
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  uadc_sync_if.snk port
);
  logic [15:0] meta_q;
  logic [15:0] sync_q;
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_q <= 16'h0000;
      sync_q <= 16'h0000;
    end
    else
    begin
      meta_q <= port.raw;
      sync_q <= meta_q;
    end
  end
  assign port.synced = sync_q;

  a_sync_two_flops: assert property // RULE15
    (@(posedge sys_clk_i) disable iff (rst_i)
    !$past(rst_i) && !$past(rst_i, 2) |-> sync_q == $past(port.raw, 2))
    else $error("synchroniser delay is not two stages");
endmodule

// file: uadc_sync_if.sv
// Interface carrying raw pin inputs to the synchroniser and results back
`timescale 1ns/10ps
interface uadc_sync_if;
  logic [15:0] raw;
  logic [15:0] synced;
  modport src (output raw, input synced);
  modport snk (input raw, output synced);
endinterface

// file: uadc_top.sv
// Attach, detach, VBUS sense and wake-up control with APB registers
// Overview of operation
// RULE1: Full-speed peripheral only, never bus master
// RULE2: Endpoints per transport; any host controller style
// RULE3: Pull D+ only when ready to enumerate
// RULE4: Select internal or external pull-up
// RULE5: Self-powered: no pull-up while VBUS off
// RULE6: VBUS sense pin number is configurable
// RULE7: Detach and wake pins configurable
// RULE8: Detach high: lines tristated, pull-up released
// RULE9: Detach low: reattach, await enumeration
// RULE10: Wake output high only while detached
// RULE11: No in-band remote wakeup while detached
// RULE12: Bus-powered: report power during enumeration
// RULE13: Suspend can switch off indicator outputs
// RULE14: Stay at 12 Mbit/s with newer hosts
// RULE15: Detach and VBUS inputs pass two flops
// RULE16: Wake drops when detach falls
//
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/10ps
module uadc_top
  import uadc_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] general_io_pin_i,
  output logic [15:0] general_io_pin_o,
  output logic [15:0] general_io_pin_oe_o,
  input wire logic engine_dplus_i,
  input wire logic engine_dminus_i,
  input wire logic engine_drive_i,
  input wire logic engine_remote_wake_i,
  output logic engine_enable_o,
  output logic engine_remote_wake_o,
  output logic [7:0] power_report_o,
  output logic [7:0] line_rate_mbps_o,
  output logic dplus_pad_o,
  output logic dplus_pad_oe_o,
  output logic dminus_pad_o,
  output logic dminus_pad_oe_o,
  output logic pullup_int_en_o,
  output logic led_enable_o,
  output logic irq_o
);
  logic [5:0] ctrl_q;
  logic [15:0] pin_q;
  logic [3:0] irq_q;
  logic [3:0] irq_d;
  logic [3:0] mask_q;
  logic [7:0] power_q;
  logic det_prev_q;
  logic vbus_prev_q;
  logic pad_dp_q;
  logic pad_dn_q;
  logic pad_oe_q;
  logic pull_int_q;
  logic pull_ext_q;
  logic wake_q;
  uadc_state_type state_q;
  uadc_state_type state_d;
  uadc_sync_if sif ();

  assign sif.raw = general_io_pin_i;
  uadc_sync u_sync
  (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .port(sif.snk)
  );

  // Pin selection from the configuration register
  wire [3:0] vbus_sel = pin_q[PIN_VBUS_LSB +: UADC_PSEL_W]; // RULE6
  wire [3:0] det_sel = pin_q[PIN_DET_LSB +: UADC_PSEL_W]; // RULE7
  wire [3:0] wake_sel = pin_q[PIN_WAKE_LSB +: UADC_PSEL_W]; // RULE7
  wire [3:0] pull_sel = pin_q[PIN_PULL_LSB +: UADC_PSEL_W]; // RULE4
  wire detach_s = sif.synced[det_sel]; // RULE15
  wire vbus_s = sif.synced[vbus_sel]; // RULE15
  wire self_pwr = ctrl_q[CTRL_SELFPWR_BIT];
  wire vbus_ok = !self_pwr || vbus_s; // RULE5
  wire ready = ctrl_q[CTRL_READY_BIT];

  // APB decode
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire hit_ctrl = paddr == UADC_CTRL_OFF;
  wire hit_pin = paddr == UADC_PIN_OFF;
  wire hit_stat = paddr == UADC_STAT_OFF;
  wire hit_irq = paddr == UADC_IRQ_OFF;
  wire hit_mask = paddr == UADC_MASK_OFF;
  wire hit_pwr = paddr == UADC_POWER_OFF;
  wire hit_any = hit_ctrl | hit_pin | hit_stat | hit_irq | hit_mask | hit_pwr;
  wire [31:0] stat_word = {24'h000000, 3'b000, wake_q, pull_int_q | pull_ext_q,
    vbus_s, detach_s, state_q == UADC_ATTACHED};
  assign pready = 1'b1;
  assign pslverr = acc && !hit_any;
  assign prdata = !acc ? 32'h00000000 :
    hit_ctrl ? {26'h0000000, ctrl_q} :
    hit_pin ? {16'h0000, pin_q} :
    hit_stat ? stat_word :
    hit_irq ? {28'h0000000, irq_q} :
    hit_mask ? {28'h0000000, mask_q} :
    hit_pwr ? {24'h000000, power_q} : 32'h00000000;

  // Connection state machine
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      UADC_OFF:
        if (detach_s)
          state_d = UADC_DETACHED; // RULE8
        else if (ready && vbus_ok)
          state_d = UADC_ATTACHED; // RULE3
      UADC_ATTACHED:
        if (detach_s)
          state_d = UADC_DETACHED; // RULE8
        else if (!ready || !vbus_ok)
          state_d = UADC_OFF; // RULE5
      UADC_DETACHED:
        if (!detach_s)
          state_d = UADC_OFF; // RULE9
      default:
        state_d = UADC_OFF;
    endcase
  end

  wire attached_d = state_d == UADC_ATTACHED;
  // Events
  wire ev_det = detach_s && !det_prev_q;
  wire ev_att = !detach_s && det_prev_q;
  wire ev_von = vbus_s && !vbus_prev_q;
  wire ev_voff = !vbus_s && vbus_prev_q;
  wire [3:0] ev = {ev_voff, ev_von, ev_att, ev_det};
  wire [3:0] irq_clr = (wr && hit_irq) ? pwdata[3:0] : 4'h0;
  // Set wins over clear
  assign irq_d = (irq_q & ~irq_clr) | ev;
  assign irq_o = |(irq_q & mask_q);

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= CTRL_RESET;
      pin_q <= PIN_RESET;
      mask_q <= MASK_RESET;
      power_q <= POWER_RESET;
      irq_q <= IRQ_RESET;
    end
    else
    begin
      if (wr && hit_ctrl)
        ctrl_q <= pwdata[5:0];
      if (wr && hit_pin)
        pin_q <= pwdata[15:0];
      if (wr && hit_mask)
        mask_q <= pwdata[3:0];
      if (wr && hit_pwr)
        power_q <= pwdata[7:0];
      irq_q <= irq_d;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q <= UADC_OFF;
      det_prev_q <= 1'b0;
      vbus_prev_q <= 1'b0;
      pad_dp_q <= 1'b0;
      pad_dn_q <= 1'b0;
      pad_oe_q <= 1'b0;
      pull_int_q <= 1'b0;
      pull_ext_q <= 1'b0;
      wake_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      det_prev_q <= detach_s;
      vbus_prev_q <= vbus_s;
      pad_dp_q <= engine_dplus_i;
      pad_dn_q <= engine_dminus_i;
      pad_oe_q <= attached_d && engine_drive_i; // RULE8
      pull_int_q <= attached_d && !ctrl_q[CTRL_EXTPU_BIT]; // RULE4
      pull_ext_q <= attached_d && ctrl_q[CTRL_EXTPU_BIT]; // RULE4
      wake_q <= state_d == UADC_DETACHED && // RULE10 RULE16
        ctrl_q[CTRL_WAKE_BIT];
    end
  end

  // Peripheral engine runs only when attached; it never starts traffic
  assign engine_enable_o = state_q == UADC_ATTACHED; // RULE1
  assign engine_remote_wake_o = engine_remote_wake_i &&
    state_q == UADC_ATTACHED; // RULE11
  assign power_report_o = self_pwr ? 8'h00 : power_q; // RULE12
  assign line_rate_mbps_o = 8'(UADC_LINE_RATE_MBPS); // RULE14
  assign dplus_pad_o = pad_dp_q; // RULE2
  assign dminus_pad_o = pad_dn_q;
  assign dplus_pad_oe_o = pad_oe_q;
  assign dminus_pad_oe_o = pad_oe_q;
  assign pullup_int_en_o = pull_int_q; // RULE3
  assign led_enable_o = !(ctrl_q[CTRL_SUSPEND_BIT] &&
    ctrl_q[CTRL_LEDOFF_BIT]); // RULE13

  // General I/O outputs: wake line and external pull-up line
  wire [15:0] wake_oh = 16'h0001 << wake_sel;
  wire [15:0] pull_oh = 16'h0001 << pull_sel;
  assign general_io_pin_o = (wake_q ? wake_oh : 16'h0000) |
    (pull_ext_q ? pull_oh : 16'h0000);
  assign general_io_pin_oe_o = wake_oh |
    (ctrl_q[CTRL_EXTPU_BIT] ? pull_oh : 16'h0000);

  a_detach_tristate: assert property // RULE8
    (@(posedge sys_clk_i) disable iff (rst_i)
    detach_s |=> !dplus_pad_oe_o && !pullup_int_en_o && !pull_ext_q)
    else $error("pads driven while detached");
  a_detach_release: assert property // RULE8
    (@(posedge sys_clk_i) disable iff (rst_i)
    detach_s |=> !dminus_pad_oe_o && !engine_enable_o)
    else $error("engine or d-minus active while detached");
  a_vbus_off_pull: assert property // RULE5
    (@(posedge sys_clk_i) disable iff (rst_i)
    self_pwr && !vbus_s |=> !pullup_int_en_o)
    else $error("pull-up on without vbus");
  a_pull_needs_ready: assert property // RULE3
    (@(posedge sys_clk_i) disable iff (rst_i)
    pullup_int_en_o |-> $past(ready))
    else $error("pull-up without ready");
  a_attach_pull: assert property // RULE3
    (@(posedge sys_clk_i) disable iff (rst_i)
    state_q == UADC_ATTACHED && !ctrl_q[CTRL_EXTPU_BIT] && $stable(ctrl_q)
    |-> pullup_int_en_o)
    else $error("pull-up off while attached");
  a_off_quiet: assert property // RULE3
    (@(posedge sys_clk_i) disable iff (rst_i)
    state_q != UADC_ATTACHED |-> !dplus_pad_oe_o && !pullup_int_en_o)
    else $error("pads or pull-up active while not attached");
  a_wake_detached: assert property // RULE10
    (@(posedge sys_clk_i) disable iff (rst_i)
    wake_q |-> state_q == UADC_DETACHED)
    else $error("wake outside detach");
  a_wake_follows: assert property // RULE10
    (@(posedge sys_clk_i) disable iff (rst_i)
    state_q == UADC_DETACHED && ctrl_q[CTRL_WAKE_BIT] && $stable(ctrl_q)
    |-> wake_q)
    else $error("wake request not shown while detached");
  a_wake_pin: assert property // RULE7
    (@(posedge sys_clk_i) disable iff (rst_i)
    wake_q |-> general_io_pin_o[wake_sel] && general_io_pin_oe_o[wake_sel])
    else $error("wake level missing on selected pin");
  a_wake_drop: assert property // RULE16
    (@(posedge sys_clk_i) disable iff (rst_i)
    $fell(detach_s) |=> !wake_q)
    else $error("wake held after detach fell");
  a_reattach: assert property // RULE9
    (@(posedge sys_clk_i) disable iff (rst_i)
    state_q == UADC_DETACHED && !detach_s && ready && vbus_ok
    |=> ##1 state_q == UADC_ATTACHED)
    else $error("no reattach");
  a_no_inband_wake: assert property // RULE11
    (@(posedge sys_clk_i) disable iff (rst_i)
    state_q != UADC_ATTACHED |-> !engine_remote_wake_o)
    else $error("in-band wake while detached");
  a_ext_pull_sel: assert property // RULE4
    (@(posedge sys_clk_i) disable iff (rst_i)
    ctrl_q[CTRL_EXTPU_BIT] && $stable(ctrl_q) |-> !pullup_int_en_o)
    else $error("internal pull-up in external mode");
  a_ext_pull_on: assert property // RULE4
    (@(posedge sys_clk_i) disable iff (rst_i)
    state_q == UADC_ATTACHED && ctrl_q[CTRL_EXTPU_BIT] && $stable(ctrl_q)
    |-> general_io_pin_o[pull_sel] && general_io_pin_oe_o[pull_sel])
    else $error("external pull-up line not driven");
  a_power_report: assert property // RULE12
    (@(posedge sys_clk_i) disable iff (rst_i)
    !self_pwr |-> power_report_o == power_q)
    else $error("power figure not reported when bus powered");
  a_led_suspend: assert property // RULE13
    (@(posedge sys_clk_i) disable iff (rst_i)
    ctrl_q[CTRL_SUSPEND_BIT] && ctrl_q[CTRL_LEDOFF_BIT] |-> !led_enable_o)
    else $error("leds on in suspend");
  a_led_on: assert property // RULE13
    (@(posedge sys_clk_i) disable iff (rst_i)
    !ctrl_q[CTRL_SUSPEND_BIT] |-> led_enable_o)
    else $error("leds off outside suspend");
  a_irq_set_wins: assert property
    (@(posedge sys_clk_i) disable iff (rst_i)
    ev[EV_DETACH_BIT] |=> irq_q[EV_DETACH_BIT])
    else $error("detach event not latched");
  a_irq_vbus_off: assert property
    (@(posedge sys_clk_i) disable iff (rst_i)
    ev[EV_VBUS_OFF_BIT] |=> irq_q[EV_VBUS_OFF_BIT])
    else $error("vbus loss event not latched");
  a_irq_clear: assert property
    (@(posedge sys_clk_i) disable iff (rst_i)
    wr && hit_irq && pwdata[EV_DETACH_BIT] && !ev[EV_DETACH_BIT]
    |=> !irq_q[EV_DETACH_BIT])
    else $error("status bit not cleared by write of one");
  a_unmapped_err: assert property
    (@(posedge sys_clk_i) disable iff (rst_i)
    acc && !hit_any |-> pslverr && prdata == 32'h00000000)
    else $error("unmapped access not refused");
endmodule

// file: usb_attach_detach_control_tb.sv
// Self-checking bench for the attach and detach control block
`timescale 1ns/10ps
module usb_attach_detach_control_tb
  import uadc_pkg::*;
;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, err, e_dp, e_dn;
  logic e_drv, e_rw, e_en, e_rwo, dp, dp_oe, dn, dn_oe, pu, led, irq, line;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] gpi, gpo, gpoe;
  logic [7:0] pwr, rate;
  int fails, n_tests, cyc;

  uadc_top DUT (.sys_clk_i(clk), .rst_i(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .general_io_pin_i(gpi), .general_io_pin_o(gpo),
    .general_io_pin_oe_o(gpoe), .engine_dplus_i(e_dp),
    .engine_dminus_i(e_dn), .engine_drive_i(e_drv),
    .engine_remote_wake_i(e_rw), .engine_enable_o(e_en),
    .engine_remote_wake_o(e_rwo), .power_report_o(pwr),
    .line_rate_mbps_o(rate), .dplus_pad_o(dp), .dplus_pad_oe_o(dp_oe),
    .dminus_pad_o(dn), .dminus_pad_oe_o(dn_oe), .pullup_int_en_o(pu),
    .led_enable_o(led), .irq_o(irq));

  uadc_host_model host (.dplus_i(dp), .dplus_oe_i(dp_oe), .pullup_i(pu),
    .ext_oe_i(gpoe[3]), .ext_i(gpo[3]), .line_o(line));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic give_verdict;
    $display("Counts: %0d checks, %0d mismatches", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      fails++;
      give_verdict;
    end
  end

  task automatic cw(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cb(input string nm, input logic e, input logic g);
    cw(nm, {31'h0, e}, {31'h0, g});
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input string nm, input logic [11:0] a,
    input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    cw(nm, e, rd);
  endtask

  task automatic settle;
    repeat (6) @(posedge clk);
  endtask

  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    gpi = 16'h0000;
    e_dp = 1'b1;
    e_dn = 1'b0;
    e_drv = 1'b1;
    e_rw = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rdc("pin", UADC_PIN_OFF, {16'h0000, PIN_RESET});
    rdc("power", UADC_POWER_OFF, {24'h000000, POWER_RESET});
    rdc("ctrl", UADC_CTRL_OFF, 32'h0);
    rdc("unmapped", 12'h0f0, 32'h0);
    cb("slverr", 1'b1, err);
    cb("no_pull", 1'b0, line);
    $display("Test reset done");
    apb(1'b1, UADC_MASK_OFF, 32'h3);
    apb(1'b1, UADC_CTRL_OFF, 32'h1);
    settle;
    cb("pull", 1'b1, pu);
    cb("engine", 1'b1, e_en);
    cb("dp_oe", 1'b1, dp_oe);
    cb("inband", 1'b1, e_rwo);
    cw("pwr", 32'h32, {24'h0, pwr});
    cw("rate", 32'(UADC_LINE_RATE_MBPS), {24'h0, rate});
    cb("dp_data", 1'b1, dp);
    cb("dn_data", 1'b0, dn);
    rdc("stat", UADC_STAT_OFF, 32'h9);
    gpi[1] <= 1'b1;
    settle;
    cb("det_pull", 1'b0, pu);
    cb("det_dp", 1'b0, dp_oe);
    cb("det_dn", 1'b0, dn_oe);
    cb("det_line", 1'b0, line);
    cb("no_inband", 1'b0, e_rwo);
    cb("irq_on", 1'b1, irq);
    cb("wake_idle", 1'b0, gpo[2]);
    apb(1'b1, UADC_CTRL_OFF, 32'h9);
    settle;
    cb("wake", 1'b1, gpo[2] & gpoe[2]);
    gpi[1] <= 1'b0;
    settle;
    cb("wake_drop", 1'b0, gpo[2]);
    cb("reattach", 1'b1, pu);
    rdc("irq_st", UADC_IRQ_OFF, 32'h3);
    apb(1'b1, UADC_IRQ_OFF, 32'h1);
    rdc("irq_w1c", UADC_IRQ_OFF, 32'h2);
    apb(1'b1, UADC_MASK_OFF, 32'h1);
    settle;
    cb("irq_mask", 1'b0, irq);
    $display("Test detach done");
    apb(1'b1, UADC_CTRL_OFF, 32'h5);
    settle;
    cb("vbus_off", 1'b0, pu);
    cw("self_pwr", 32'h0, {24'h0, pwr});
    gpi[0] <= 1'b1;
    settle;
    cb("vbus_on", 1'b1, pu);
    rdc("irq_von", UADC_IRQ_OFF, 32'h6);
    gpi[0] <= 1'b0;
    settle;
    cb("vbus_drop", 1'b0, pu);
    rdc("irq_voff", UADC_IRQ_OFF, 32'he);
    $display("Test vbus done");
    e_drv <= 1'b0;
    apb(1'b1, UADC_PIN_OFF, 32'h3250);
    apb(1'b1, UADC_CTRL_OFF, 32'h3);
    settle;
    cb("ext_oe", 1'b1, gpoe[3]);
    cb("int_off", 1'b0, pu);
    cb("ext_line", 1'b1, line);
    gpi[1] <= 1'b1;
    settle;
    cb("old_pin", 1'b1, line);
    gpi[5] <= 1'b1;
    settle;
    cb("new_pin", 1'b0, line);
    gpi[5] <= 1'b0;
    cb("led_on", 1'b1, led);
    apb(1'b1, UADC_CTRL_OFF, 32'h31);
    settle;
    cb("led_off", 1'b0, led);
    $display("Test config done");
    give_verdict;
  end
endmodule
